// File: hdl/tpc_clk_if.sv
/*
 * Link between the counter control and the clock generator.
 * Assumes both ends run on the same bus clock.
 */
`default_nettype none

interface tpc_clk_if;
	import tpc_pkg::*;
	tpc_clks_type clock_source_select;
	logic [2:0] prescale_select;
	logic tick;

	modport ctrl (output clock_source_select, output prescale_select, input tick);
	modport gen (input clock_source_select, input prescale_select, output tick);
endinterface

`default_nettype wire

// File: hdl/tpc_clock_gen.sv
/*
 * Clock source selection, synchronisers and power-of-two prescaler.
 * Assumes the pin clocks are far slower than mclk and asynchronous to it.
 */
`default_nettype none

module tpc_clock_gen
	import tpc_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic external_timer_clock,
	input wire logic fixed_system_clock,
	tpc_clk_if.gen clk_bus
);

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic ext_s1_q, ext_s2_q, ext_s3_q;
	logic fix_s1_q, fix_s2_q, fix_s3_q;
	logic [6:0] pre_q;
	logic tick_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			fix_s1_q <= 1'b0;
			fix_s2_q <= 1'b0;
			fix_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= external_timer_clock;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			fix_s1_q <= fixed_system_clock;
			fix_s2_q <= fix_s1_q;
			fix_s3_q <= fix_s2_q;
		end
	end

	// ----------------------------------------------------------------
	// Source selection and prescaler
	// ----------------------------------------------------------------
	wire logic ext_rise = ext_s2_q & ~ext_s3_q;
	wire logic fix_rise = fix_s2_q & ~fix_s3_q;
	wire logic src_off = (clk_bus.clock_source_select == CLKS_OFF);
	wire logic src_tick = (clk_bus.clock_source_select == CLKS_BUS) ||
		((clk_bus.clock_source_select == CLKS_FIXED) && fix_rise) ||
		((clk_bus.clock_source_select == CLKS_EXT) && ext_rise);
	wire logic [6:0] pre_mask = 7'((8'h01 << clk_bus.prescale_select) - 8'h01);
	wire logic tick_d = src_tick && ((pre_q & pre_mask) == pre_mask);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pre_q <= PRESCALE_ZERO;
			tick_q <= 1'b0;
		end else begin
			pre_q <= src_off ? PRESCALE_ZERO : (src_tick ? pre_q + 7'h01 : pre_q);
			tick_q <= tick_d;
		end
	end

	assign clk_bus.tick = tick_q;

endmodule

`default_nettype wire

// File: hdl/tpc_pkg.sv
/*
 * Shared constants and types of the timer/PWM counter block.
 * Assumes an 8-bit register port and byte-wide registers.
 */
`default_nettype none

package tpc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNTER_HI = 8'h01;
	localparam logic [7:0] OFS_COUNTER_LO = 8'h02;
	localparam logic [7:0] OFS_MODULO_HI = 8'h03;
	localparam logic [7:0] OFS_MODULO_LO = 8'h04;
	localparam logic [7:0] OFS_CHAN_BASE = 8'h05;
	localparam logic [7:0] OFS_CHAN_STRIDE = 8'h03;
	localparam logic [7:0] OFS_CHAN_VAL_HI = 8'h01;
	localparam logic [7:0] OFS_CHAN_VAL_LO = 8'h02;

	// ----------------------------------------------------------------
	// Field positions of the status/control registers
	// ----------------------------------------------------------------
	localparam int FLAG_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	localparam int CENTER_BIT = 5;
	localparam int CLKS_HI = 4;
	localparam int CLKS_LO = 3;
	localparam int PS_HI = 2;
	localparam int PS_LO = 0;
	localparam int CH_MS_HI = 5;
	localparam int CH_MS_LO = 4;
	localparam int CH_ELS_HI = 3;
	localparam int CH_ELS_LO = 2;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] MODULO_FULL = 16'hffff;
	localparam logic [15:0] MODULO_RESET = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [6:0] PRESCALE_ZERO = 7'h00;

	typedef enum logic [1:0] {
		CLKS_OFF = 2'b00,
		CLKS_BUS = 2'b01,
		CLKS_FIXED = 2'b10,
		CLKS_EXT = 2'b11
	} tpc_clks_type;

	typedef enum logic [1:0] {
		ELS_NONE = 2'b00,
		ELS_A = 2'b01,
		ELS_B = 2'b10,
		ELS_AB = 2'b11
	} tpc_els_type;

	localparam logic [1:0] MS_CAPTURE = 2'b00;
	localparam logic [1:0] MS_COMPARE = 2'b01;

endpackage

`default_nettype wire

// File: hdl/tpc_timer.sv
/*
 * Timer/PWM counter core with its channels and register port.
 * Assumes a one-cycle strobe register master and the port pin logic
 * outside, which takes pin_out and pin_oe_n as the pad drive.
 */
// Design decisions made here: the address map and the address-and-strobe port.
`default_nettype none

module tpc_timer
	import tpc_pkg::*;
#(
	parameter int NUM_CH = 2
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic external_timer_clock,
	input wire logic fixed_system_clock,
	input wire logic [NUM_CH-1:0] chan_pin_in,
	input wire logic [NUM_CH-1:0] port_data,
	input wire logic [NUM_CH-1:0] port_dir,
	input wire logic [NUM_CH-1:0] port_pullup,
	output logic [NUM_CH-1:0] chan_pin_out,
	output logic [NUM_CH-1:0] chan_pin_oe_n,
	output logic [NUM_CH-1:0] chan_pullup_en,
	output logic ovf_irq,
	output logic [NUM_CH-1:0] chan_irq
);

	// ----------------------------------------------------------------
	// Module control state
	// ----------------------------------------------------------------
	tpc_clk_if clk_bus ();

	logic overflow_flag_q, ovf_arm_q, overflow_irq_enable_q, center_aligned_select_q;
	tpc_clks_type clks_q;
	logic [2:0] ps_q;
	logic [15:0] cnt_q, cnt_d, mod_q;
	logic dir_up_q, dir_up_d, ovf_ev, ovf_irq_q;
	logic [7:0] rdata_q, rd_d;
	logic [7:0] ch_rd [NUM_CH];

	tpc_clock_gen u_clock_gen (
		.mclk(mclk),
		.nrst(nrst),
		.external_timer_clock(external_timer_clock),
		.fixed_system_clock(fixed_system_clock),
		.clk_bus(clk_bus)
	);

	assign clk_bus.clock_source_select = clks_q;
	assign clk_bus.prescale_select = ps_q;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire logic sel_sc = (addr == OFS_STATUS_CONTROL);
	wire logic sel_cnt = (addr == OFS_COUNTER_HI) || (addr == OFS_COUNTER_LO);
	wire logic wr_sc = wr && sel_sc;
	wire logic rd_sc = rd && sel_sc;
	// any counter byte write clears it
	wire logic cnt_wr = wr && sel_cnt;
	wire logic tick = clk_bus.tick;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// zero modulo counts full range
	wire logic [15:0] mod_eff = (mod_q == MODULO_RESET) ? MODULO_FULL : mod_q;
	wire logic at_mod = (cnt_q == mod_eff);

	always_comb begin
		cnt_d = cnt_q;
		dir_up_d = dir_up_q;
		ovf_ev = 1'b0;
		if (cnt_wr) begin
			cnt_d = COUNT_ZERO;
			dir_up_d = 1'b1;
		end else if (tick) begin
			if (!center_aligned_select_q) begin
				cnt_d = at_mod ? COUNT_ZERO : cnt_q + COUNT_ONE;
				ovf_ev = at_mod;
			end else if (dir_up_q) begin
				if (at_mod) begin
					cnt_d = cnt_q - COUNT_ONE;
					dir_up_d = 1'b0;
					ovf_ev = 1'b1;
				end else begin
					cnt_d = cnt_q + COUNT_ONE;
				end
			end else if (cnt_q == COUNT_ZERO) begin
				cnt_d = cnt_q + COUNT_ONE;
				dir_up_d = 1'b1;
			end else begin
				cnt_d = cnt_q - COUNT_ONE;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= COUNT_ZERO;
			dir_up_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			dir_up_q <= dir_up_d;
		end
	end

	// ----------------------------------------------------------------
	// Status/control and modulo registers
	// ----------------------------------------------------------------
	// flag clear sequence, set wins
	wire logic ovf_clr = wr_sc && !wdata[FLAG_BIT] && ovf_arm_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			overflow_flag_q <= 1'b0;
			ovf_arm_q <= 1'b0;
			overflow_irq_enable_q <= 1'b0;
			center_aligned_select_q <= 1'b0;
			clks_q <= CLKS_OFF;
			ps_q <= 3'h0;
			mod_q <= MODULO_RESET;
			ovf_irq_q <= 1'b0;
		end else begin
			overflow_flag_q <= ovf_ev || (overflow_flag_q && !ovf_clr);
			ovf_arm_q <= !ovf_ev && !wr_sc && (ovf_arm_q || (rd_sc && overflow_flag_q));
			if (wr_sc) begin
				overflow_irq_enable_q <= wdata[IRQ_EN_BIT];
				center_aligned_select_q <= wdata[CENTER_BIT];
				clks_q <= tpc_clks_type'(wdata[CLKS_HI:CLKS_LO]);
				ps_q <= wdata[PS_HI:PS_LO];
			end
			if (wr && addr == OFS_MODULO_HI) begin
				mod_q[15:8] <= wdata;
			end
			if (wr && addr == OFS_MODULO_LO) begin
				mod_q[7:0] <= wdata;
			end
			ovf_irq_q <= overflow_flag_q && overflow_irq_enable_q;
		end
	end

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	// independent channel configuration
	for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
		localparam logic [7:0] A_SC = 8'(OFS_CHAN_BASE + 8'(n) * OFS_CHAN_STRIDE);
		localparam logic [7:0] A_VH = 8'(A_SC + OFS_CHAN_VAL_HI);
		localparam logic [7:0] A_VL = 8'(A_SC + OFS_CHAN_VAL_LO);

		logic flag_q, arm_q, ie_q, out_q, out_d, irq_q;
		logic [1:0] ms_q;
		tpc_els_type els_q;
		logic [15:0] val_q, act_q;
		logic s1_q, s2_q, s3_q, pin_out_q, pin_oe_n_q, pull_q;

		wire logic c_sel_sc = (addr == A_SC);
		wire logic c_wr_sc = wr && c_sel_sc;
		wire logic capture = !center_aligned_select_q && (ms_q == MS_CAPTURE);
		wire logic compare = !center_aligned_select_q && (ms_q == MS_COMPARE);
		wire logic epwm = !center_aligned_select_q && ms_q[1];
		wire logic pwm = epwm || center_aligned_select_q;
		wire logic low_true = els_q[0];
		// pin needed only when edge/level bits are set
		// pin left to port data and direction when bits are 0:0
		wire logic owned = (els_q != ELS_NONE);
		wire logic rise = s2_q && !s3_q;
		wire logic fall = !s2_q && s3_q;
		// capture on rising, falling or any edge
		wire logic cap_ev = capture && (((els_q == ELS_A) && rise) ||
			((els_q == ELS_B) && fall) || ((els_q == ELS_AB) && (rise || fall)));
		wire logic match_ev = tick && !capture && (cnt_q == (pwm ? act_q : val_q));
		wire logic ch_ev = cap_ev || match_ev;
		wire logic ch_clr = c_wr_sc && !wdata[FLAG_BIT] && arm_q;

		always_comb begin
			out_d = out_q;
			if (compare && match_ev) begin
				if (els_q == ELS_A) begin
					out_d = !out_q;
				end else if (els_q == ELS_B) begin
					out_d = 1'b0;
				end else if (els_q == ELS_AB) begin
					out_d = 1'b1;
				end
			end else if (epwm && ovf_ev) begin
				out_d = !low_true;
			end else if (epwm && match_ev) begin
				out_d = low_true;
			end else if (center_aligned_select_q) begin
				out_d = (cnt_q < act_q) ^ low_true;
			end
		end

		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
			end else begin
				s1_q <= chan_pin_in[n];
				s2_q <= s1_q;
				s3_q <= s2_q;
			end
		end

		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				flag_q <= 1'b0;
				arm_q <= 1'b0;
				ie_q <= 1'b0;
				ms_q <= MS_CAPTURE;
				els_q <= ELS_NONE;
				val_q <= COUNT_ZERO;
				act_q <= COUNT_ZERO;
				out_q <= 1'b0;
				irq_q <= 1'b0;
			end else begin
				flag_q <= ch_ev || (flag_q && !ch_clr);
				arm_q <= !ch_ev && !c_wr_sc && (arm_q || (rd && c_sel_sc && flag_q));
				if (c_wr_sc) begin
					ie_q <= wdata[IRQ_EN_BIT];
					ms_q <= wdata[CH_MS_HI:CH_MS_LO];
					els_q <= tpc_els_type'(wdata[CH_ELS_HI:CH_ELS_LO]);
				end
				if (cap_ev) begin
					val_q <= cnt_q;
				end else if (wr && addr == A_VH) begin
					val_q[15:8] <= wdata;
				end else if (wr && addr == A_VL) begin
					val_q[7:0] <= wdata;
				end
				// Duty value buffered until overflow in PWM modes
				if (!pwm || ovf_ev) begin
					act_q <= val_q;
				end
				out_q <= out_d;
				irq_q <= flag_q && ie_q;
			end
		end

		// pins start as inputs with pullups off
		// owned pins ignore port data and direction
		always_ff @(posedge mclk or negedge nrst) begin
			if (!nrst) begin
				pin_out_q <= 1'b0;
				pin_oe_n_q <= 1'b1;
				pull_q <= 1'b0;
			end else begin
				pin_out_q <= owned ? out_q : port_data[n];
				pin_oe_n_q <= owned ? capture : !port_dir[n];
				pull_q <= port_pullup[n] && owned && capture;
			end
		end

		assign ch_rd[n] = c_sel_sc ? {flag_q, ie_q, ms_q, els_q, 2'b00} :
			(addr == A_VH) ? val_q[15:8] :
			(addr == A_VL) ? val_q[7:0] : BYTE_ZERO;
		assign chan_pin_out[n] = pin_out_q;
		assign chan_pin_oe_n[n] = pin_oe_n_q;
		assign chan_pullup_en[n] = pull_q;
		assign chan_irq[n] = irq_q;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rd_d = BYTE_ZERO;
		if (sel_sc) begin
			rd_d = {overflow_flag_q, overflow_irq_enable_q, center_aligned_select_q, clks_q, ps_q};
		end else if (addr == OFS_COUNTER_HI) begin
			rd_d = cnt_q[15:8];
		end else if (addr == OFS_COUNTER_LO) begin
			rd_d = cnt_q[7:0];
		end else if (addr == OFS_MODULO_HI) begin
			rd_d = mod_q[15:8];
		end else if (addr == OFS_MODULO_LO) begin
			rd_d = mod_q[7:0];
		end
		for (int i = 0; i < NUM_CH; i++) begin
			rd_d = rd_d | ch_rd[i];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= BYTE_ZERO;
		end else begin
			rdata_q <= rd ? rd_d : BYTE_ZERO;
		end
	end

	assign rdata = rdata_q;
	assign ovf_irq = ovf_irq_q;

endmodule

`default_nettype wire

// File: verification/tb_timer_pwm_counter_control.sv
/*
 * Self-checking bench for the timer core, driving its ports directly.
 * Assumes the checker is bound to the core by its own file.
 */
`default_nettype none

module tb_timer_pwm_counter_control;
	timeunit 1ns;
	timeprecision 100ps;
	import tpc_pkg::*;

	logic mclk, nrst, wr, rd, ext_clk, fix_clk;
	logic [7:0] addr, wdata, rv;
	logic [1:0] pin_in, p_data, p_dir, p_pull;
	wire logic [7:0] rdata;
	wire logic [1:0] pin_out, oe_n, pull_en, chan_irq;
	wire logic ovf_irq;
	int mismatches, checked, k, i, d;
	logic [31:0] seed = 32'h0000d956;
	logic [15:0] cnt, cnt2, mv;
	logic [7:0] vals [12];
	logic [7:0] rst_ofs [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h40};
	logic ok, eq;

	tpc_timer #(.NUM_CH(2)) tpc_timer_i (.mclk(mclk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_timer_clock(ext_clk),
		.fixed_system_clock(fix_clk), .chan_pin_in(pin_in), .port_data(p_data),
		.port_dir(p_dir), .port_pullup(p_pull), .chan_pin_out(pin_out),
		.chan_pin_oe_n(oe_n), .chan_pullup_en(pull_en), .ovf_irq(ovf_irq),
		.chan_irq(chan_irq));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int exp_steps(input int dur, input int ps);
		return dur >> ps;
	endfunction

	task automatic conclude();
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic rcnt(output logic [15:0] c);
		rreg(OFS_COUNTER_HI, c[15:8]);
		rreg(OFS_COUNTER_LO, c[7:0]);
	endtask

	// Stop, load modulo, clear counter, then start with the given control byte
	task automatic setup(input logic [15:0] m, input logic [7:0] sc);
		wreg(OFS_STATUS_CONTROL, 8'h00);
		wreg(OFS_MODULO_HI, m[15:8]);
		wreg(OFS_MODULO_LO, m[7:0]);
		wreg(OFS_COUNTER_LO, 8'h00);
		wreg(OFS_STATUS_CONTROL, sc);
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		conclude();
	end

	initial begin
		nrst = 1'b0;
		{wr, rd, ext_clk, fix_clk} = 4'h0;
		{addr, wdata} = 16'h0000;
		{pin_in, p_data, p_dir, p_pull} = 8'h00;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1;
		chk(16'(oe_n), 16'h0003);
		chk(16'(pull_en), 16'h0000);
		foreach (rst_ofs[j]) begin
			rreg(rst_ofs[j], rv);
			chk(16'(rv), 16'h0000);
		end
		for (i = 0; i < 4; i++) begin
			@(posedge mclk);
			p_data <= 2'(rnd());
			p_dir <= 2'(rnd());
			p_pull <= 2'(rnd());
			pin_in <= 2'(rnd());
			repeat (4) @(posedge mclk);
			#1;
			chk(16'(pin_out), 16'(p_data));
			chk(16'(oe_n ^ p_dir), 16'h0003);
			chk(16'(pull_en), 16'h0000);
		end
		wreg(OFS_CHAN_BASE, 8'h1c);
		wreg(OFS_CHAN_BASE + OFS_CHAN_STRIDE, 8'h04);
		@(posedge mclk);
		p_dir <= 2'b11;
		p_pull <= 2'b11;
		repeat (4) @(posedge mclk);
		#1;
		chk(16'(oe_n), 16'h0002);
		chk(16'(pull_en), 16'h0002);
		rreg(OFS_CHAN_BASE, rv);
		chk(16'(rv), 16'h001c);
		wreg(OFS_CHAN_BASE, 8'h00);
		wreg(OFS_CHAN_BASE + OFS_CHAN_STRIDE, 8'h00);
		for (k = 0; k < 8; k++) begin
			d = 20 << k;
			setup(16'h0000, {3'b000, CLKS_BUS, 3'(k)});
			repeat (d) @(posedge mclk);
			wreg(OFS_STATUS_CONTROL, 8'h00);
			rcnt(cnt);
			ok = int'(cnt) >= exp_steps(d, k) - 3 && int'(cnt) <= exp_steps(d, k) + 3;
			chk(16'(ok), 16'h0001);
			repeat (20) @(posedge mclk);
			rcnt(cnt2);
			chk(cnt2, cnt);
		end
		wreg(OFS_COUNTER_HI, 8'h00);
		rreg(OFS_COUNTER_HI, rv);
		chk(16'(rv), 16'h0000);
		for (i = 0; i < 4; i++) begin
			mv = (i == 0) ? 16'h0001 : 16'(rnd() % 32) + 16'h0001;
			setup(mv, 8'h48);
			repeat (3 * int'(mv) + 10) @(posedge mclk);
			wreg(OFS_STATUS_CONTROL, 8'h40);
			rcnt(cnt);
			chk(16'(cnt <= mv), 16'h0001);
			rreg(OFS_STATUS_CONTROL, rv);
			chk(16'(rv), 16'h00c0);
			chk(16'(ovf_irq), 16'h0001);
			wreg(OFS_STATUS_CONTROL, 8'h40);
			rreg(OFS_STATUS_CONTROL, rv);
			chk(16'(rv), 16'h0040);
			chk(16'(ovf_irq), 16'h0000);
			wreg(OFS_STATUS_CONTROL, 8'hc0);
			rreg(OFS_STATUS_CONTROL, rv);
			chk(16'(rv), 16'h0040);
		end
		setup(16'h0002, 8'h08);
		repeat (8) @(posedge mclk);
		rreg(OFS_STATUS_CONTROL, rv);
		repeat (6) @(posedge mclk);
		wreg(OFS_STATUS_CONTROL, 8'h00);
		rreg(OFS_STATUS_CONTROL, rv);
		chk(16'(rv), 16'h0080);
		wreg(OFS_STATUS_CONTROL, 8'h00);
		setup(16'h0003, 8'h28);
		for (i = 0; i < 12; i++)
			rreg(OFS_COUNTER_LO, vals[i]);
		rreg(OFS_STATUS_CONTROL, rv);
		ok = 1'b1;
		eq = 1'b0;
		for (i = 0; i < 11; i++) begin
			ok &= vals[i] <= 8'h03;
			eq |= vals[i] === vals[i + 1];
		end
		chk(16'(ok), 16'h0001);
		chk(16'(eq), 16'h0001);
		chk(16'(rv[7]), 16'h0001);
		// Compare set on channel 0, fourteen bus ticks leave the count at 4
		wreg(OFS_STATUS_CONTROL, 8'h00);
		wreg(OFS_CHAN_BASE + OFS_CHAN_VAL_LO, 8'h05);
		wreg(OFS_CHAN_BASE, 8'h5c);
		wreg(OFS_CHAN_BASE + OFS_CHAN_STRIDE, 8'h04);
		pin_in <= 2'b00;
		setup(16'h0009, 8'h08);
		repeat (12) @(posedge mclk);
		wreg(OFS_STATUS_CONTROL, 8'h00);
		#1;
		chk(16'(pin_out[0]), 16'h0001);
		chk(16'(chan_irq[0]), 16'h0001);
		rreg(OFS_CHAN_BASE, rv);
		chk(16'(rv), 16'h00dc);
		wreg(OFS_CHAN_BASE, 8'h1c);
		rreg(OFS_CHAN_BASE, rv);
		chk(16'(rv), 16'h001c);
		chk(16'(chan_irq[0]), 16'h0000);
		// Rising edge on channel 1 captures the held count
		rcnt(cnt);
		chk(cnt, 16'h0004);
		@(posedge mclk);
		pin_in <= 2'b10;
		repeat (6) @(posedge mclk);
		rreg(OFS_CHAN_BASE + OFS_CHAN_STRIDE + OFS_CHAN_VAL_LO, rv);
		chk(16'(rv), 16'(cnt[7:0]));
		rreg(OFS_CHAN_BASE + OFS_CHAN_STRIDE, rv);
		chk(16'(rv), 16'h0084);
		// High-true edge PWM with duty 3 ends inactive at count 4
		wreg(OFS_CHAN_BASE + OFS_CHAN_VAL_LO, 8'h03);
		wreg(OFS_CHAN_BASE, 8'h28);
		setup(16'h0009, 8'h08);
		repeat (12) @(posedge mclk);
		wreg(OFS_STATUS_CONTROL, 8'h00);
		repeat (3) @(posedge mclk);
		#1;
		chk(16'(pin_out[0]), 16'h0000);
		wreg(OFS_CHAN_BASE, 8'h00);
		wreg(OFS_CHAN_BASE + OFS_CHAN_STRIDE, 8'h00);
		for (i = 0; i < 2; i++) begin
			setup(16'h0000, {3'b000, (i == 1) ? CLKS_EXT : CLKS_FIXED, 3'b000});
			repeat (10) begin
				repeat (5) @(posedge mclk);
				ext_clk <= (i == 1);
				fix_clk <= (i == 0);
				repeat (5) @(posedge mclk);
				ext_clk <= 1'b0;
				fix_clk <= 1'b0;
			end
			repeat (8) @(posedge mclk);
			wreg(OFS_STATUS_CONTROL, 8'h00);
			rcnt(cnt);
			chk(cnt, 16'(exp_steps(10, 0)));
		end
		conclude();
	end
endmodule

`default_nettype wire

// File: verification/tpc_timer_asserts.sv
/*
 * Concurrent checks on the register port and pad outputs of the timer core.
 * Assumes it is bound to tpc_timer and sees only that module's ports.
 */
`default_nettype none

module tpc_timer_asserts
	import tpc_pkg::*;
#(
	parameter int NUM_CH = 2
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic external_timer_clock,
	input wire logic fixed_system_clock,
	input wire logic [NUM_CH-1:0] chan_pin_in,
	input wire logic [NUM_CH-1:0] port_data,
	input wire logic [NUM_CH-1:0] port_dir,
	input wire logic [NUM_CH-1:0] port_pullup,
	input wire logic [NUM_CH-1:0] chan_pin_out,
	input wire logic [NUM_CH-1:0] chan_pin_oe_n,
	input wire logic [NUM_CH-1:0] chan_pullup_en,
	input wire logic ovf_irq,
	input wire logic [NUM_CH-1:0] chan_irq
);
	// ----------------------------------------------------------------
	// Read decode history
	// ----------------------------------------------------------------
	localparam int LAST_OFS = int'(OFS_CHAN_BASE) + int'(OFS_CHAN_STRIDE) * NUM_CH - 1;
	wire logic hole_addr = int'(addr) > LAST_OFS;
	wire logic ch_addr = addr >= OFS_CHAN_BASE && !hole_addr
		&& ((addr - OFS_CHAN_BASE) % OFS_CHAN_STRIDE) == 8'h00;
	logic rd_any_q, rd_sc_q, rd_ch_q, rd_hole_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_any_q <= 1'b0;
			rd_sc_q <= 1'b0;
			rd_ch_q <= 1'b0;
			rd_hole_q <= 1'b0;
		end else begin
			rd_any_q <= rd;
			rd_sc_q <= rd && addr == OFS_STATUS_CONTROL;
			rd_ch_q <= rd && ch_addr;
			rd_hole_q <= rd && hole_addr;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_rdata_idle_zero: assert property (!rd_any_q |-> rdata == 8'h00)
		else $error("read data not zero outside read answer cycle");
	a_irq_flag_enable: assert property (rd_sc_q |-> ovf_irq == (rdata[7] & rdata[6]))
		else $error("overflow request differs from flag and enable");
	a_reset_pins_idle: assert property (!$past(nrst) |-> (&chan_pin_oe_n)
		&& chan_pullup_en == '0 && !ovf_irq && chan_irq == '0)
		else $error("pads or requests active after reset");
	a_pullup_input_only: assert property ((chan_pullup_en & ~chan_pin_oe_n) == '0)
		else $error("pullup enabled on a driven pin");
	a_unmapped_reads_zero: assert property (rd_hole_q |-> rdata == 8'h00)
		else $error("unmapped address returned data");
	a_chan_low_bits: assert property (rd_ch_q |-> rdata[1:0] == 2'b00)
		else $error("channel control low bits not zero");
	a_counter_write_clear: assert property ((wr && (addr == OFS_COUNTER_HI
		|| addr == OFS_COUNTER_LO)) ##[1:3] (rd && addr == OFS_COUNTER_HI) |=> rdata == 8'h00)
		else $error("counter not cleared by byte write");
	a_irq_disable_drops: assert property ((wr && addr == OFS_STATUS_CONTROL
		&& !wdata[IRQ_EN_BIT]) ##1 !(wr && addr == OFS_STATUS_CONTROL) |=> !ovf_irq)
		else $error("overflow request stays with enable cleared");
endmodule

bind tpc_timer tpc_timer_asserts #(.NUM_CH(NUM_CH)) tpc_timer_asserts_i (
	.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.external_timer_clock(external_timer_clock), .fixed_system_clock(fixed_system_clock),
	.chan_pin_in(chan_pin_in), .port_data(port_data), .port_dir(port_dir),
	.port_pullup(port_pullup), .chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n),
	.chan_pullup_en(chan_pullup_en), .ovf_irq(ovf_irq), .chan_irq(chan_irq)
);

`default_nettype wire
